// >>> charge_option_defines.vh
`ifndef CHARGE_OPTION_DEFINES_VH
`define CHARGE_OPTION_DEFINES_VH

// register address and reset value
`define CTRL_ADDR          8'h30
`define CTRL_RESET         8'h00

// field positions inside the control byte
`define BIT_REF_SEL        7
`define BIT_POLARITY       6
`define BIT_DEG_HI         5
`define BIT_DEG_LO         4
`define BIT_TRIP_DISABLE   3
`define BIT_PASS_THROUGH   2
`define BIT_SHIP_DISCHARGE 1
`define BIT_AUTO_WAKEUP    0

// deglitch codes
`define DEG_CODE_5US       2'h0
`define DEG_CODE_2MS       2'h1
`define DEG_CODE_20MS      2'h2
`define DEG_CODE_5S        2'h3

// clock and times in their own units
`define CLK_HZ             64'd10000000
`define DEG_CODE0_US       64'd5
`define DEG_CODE1_MS       64'd2
`define DEG_CODE2_MS       64'd20
`define DEG_CODE3_S        64'd5
`define SHIP_WINDOW_MS     64'd140
`define WAKE_LIMIT_MIN     64'd30

// short count stays here, long ones are top-level parameters
`define DEG_CODE0_CYC      (`DEG_CODE0_US * `CLK_HZ / 64'd1000000)

// timer width, enough for the 30 minute limit
`define TIMER_W            36

`endif

// >>> cycle_timer.v
`timescale 1ns/10ps
`include "charge_option_defines.vh"

// counts while run is high, raises done after limit cycles
module cycle_timer (
    // clock and reset
    input  wire                    clk,
    input  wire                    reset,
    // control
    input  wire                    run,
    input  wire [`TIMER_W-1:0]     limit,
    // status
    output reg                     done_q
);

    reg [`TIMER_W-1:0] count_q;

    // dropping run restarts the count from zero
    always @(posedge clk) begin
        if (reset || !run) begin
            count_q <= {`TIMER_W{1'b0}};
            done_q  <= 1'b0;
        end else if (count_q >= limit - {{(`TIMER_W-1){1'b0}}, 1'b1}) begin
            done_q  <= 1'b1;
        end else begin
            count_q <= count_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // cycle_timer

// >>> charge_option_control.v
`timescale 1ns/10ps
`include "charge_option_defines.vh"

// Notes on behaviour
// - reference select bit: 0 picks 2.3 V threshold (default), 1 picks 1.2 V
// - polarity 0: output low when input above; polarity 1: low when below
// - deglitch delays only falling edges of comparator output; rising passes at once
// - deglitch codes 00/01/10/11 give 5 us, 2 ms, 20 ms, 5 s; comparator enabled
// - trip with force-off enabled latches converter off and drops charger good
// - while latched, effective charge current forced zero; stored setting untouched
// - release needs comparator high first, then force-off bit cleared, in that order
// - pass-through enable defaults 0; writing 1 enables mode and bit self-clears
// - ship discharge bit set sinks about 20 mA from sense pin for 140 ms
// - at end of 140 ms window the ship discharge bit clears itself
// - host writing 0 to ship discharge bit stops discharge immediately
// - auto wakeup with battery below minimum charges at 256 mA, 30 minutes max
// - battery above minimum during auto wakeup ends charge and clears the bit
// - a write of the charge current register ends auto wakeup charging
module charge_option_control #(
    parameter [63:0] DEG1_CYC = `DEG_CODE1_MS * (`CLK_HZ / 64'd1000),
    parameter [63:0] DEG2_CYC = `DEG_CODE2_MS * (`CLK_HZ / 64'd1000),
    parameter [63:0] DEG3_CYC = `DEG_CODE3_S * `CLK_HZ,
    parameter [63:0] SHIP_CYC = `SHIP_WINDOW_MS * (`CLK_HZ / 64'd1000),
    parameter [63:0] WAKE_CYC = `WAKE_LIMIT_MIN * 64'd60 * `CLK_HZ
) (
    // clock and reset
    input  wire       clk,
    input  wire       reset,
    // byte access from the serial host engine
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_q,
    // write strobe of the charge current register
    input  wire       charge_current_write,
    // analog front end results, asynchronous
    input  wire       comparator_input_above_2v3,
    input  wire       comparator_input_above_1v2,
    input  wire       battery_below_minimum_system_voltage,
    // outputs to power stage and pins
    output reg        comparator_output_q,
    output reg        charger_good_indication_q,
    output reg        converter_latched_off_q,
    output reg        charge_current_force_zero_q,
    output reg        pass_through_mode_q,
    output reg        battery_sense_negative_pin_sink_q,
    output reg        auto_wakeup_charge_256ma_q
);

    // control fields
    reg        ref_sel_q;
    reg        polarity_q;
    reg  [1:0] deg_sel_q;
    reg        trip_disable_q;
    reg        pass_enable_q;
    reg        ship_req_q;
    reg        wake_en_q;
    reg        released_q;

    // synchronised analog inputs, three flip-flops, stable on agreement
    reg  [2:0] sync1_q;
    reg  [2:0] sync2_q;
    reg  [2:0] sync3_q;
    reg  [2:0] stable_q;
    wire [2:0] async_in = {battery_below_minimum_system_voltage,
                           comparator_input_above_1v2,
                           comparator_input_above_2v3};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_sync
            // a change counts only once stages two and three agree
            always @(posedge clk) begin
                if (reset) begin
                    sync1_q[g]  <= 1'b0;
                    sync2_q[g]  <= 1'b0;
                    sync3_q[g]  <= 1'b0;
                    stable_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= async_in[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        stable_q[g] <= sync3_q[g];
                    end
                end
            end
        end
    endgenerate

    wire battery_low = stable_q[2];
    wire ctrl_wr     = reg_wr && (reg_addr == `CTRL_ADDR);

    // short deglitch count, cut to timer width on purpose
    localparam [63:0] DEG0_CYC = `DEG_CODE0_CYC;

    wire input_above = ref_sel_q ? stable_q[1] : stable_q[0];
    wire want_low    = polarity_q ? !input_above : input_above;

    reg [`TIMER_W-1:0] deg_limit;
    always @* begin
        case (deg_sel_q)
            `DEG_CODE_5US: deg_limit = DEG0_CYC[`TIMER_W-1:0];
            `DEG_CODE_2MS: deg_limit = DEG1_CYC[`TIMER_W-1:0];
            `DEG_CODE_20MS: deg_limit = DEG2_CYC[`TIMER_W-1:0];
            default: deg_limit = DEG3_CYC[`TIMER_W-1:0];
        endcase
    end

    wire deg_done;
    wire ship_done;
    wire wake_done;
    wire wake_active = wake_en_q && battery_low;

    // falling-edge qualifier, runs only while output high wants to go low
    cycle_timer u_deglitch (
        .clk    (clk),
        .reset  (reset),
        .run    (want_low && comparator_output_q),
        .limit  (deg_limit),
        .done_q (deg_done)
    );

    // ship discharge window
    cycle_timer u_ship (
        .clk    (clk),
        .reset  (reset),
        .run    (ship_req_q),
        .limit  (SHIP_CYC[`TIMER_W-1:0]),
        .done_q (ship_done)
    );

    // auto wakeup charge limit
    cycle_timer u_wake (
        .clk    (clk),
        .reset  (reset),
        .run    (wake_active),
        .limit  (WAKE_CYC[`TIMER_W-1:0]),
        .done_q (wake_done)
    );

    // comparator output; output is high when nothing wants it low
    always @(posedge clk) begin
        if (reset) begin
            comparator_output_q <= 1'b1;
        end else if (!want_low) begin
            comparator_output_q <= 1'b1;
        end else if (deg_done) begin
            comparator_output_q <= 1'b0;
        end
    end

    // control byte; host writes land after hardware clears, so a set wins
    always @(posedge clk) begin
        if (reset) begin
            ref_sel_q      <= 1'b0;
            polarity_q     <= 1'b0;
            deg_sel_q      <= `DEG_CODE_5US;
            trip_disable_q <= 1'b0;
            pass_enable_q  <= 1'b0;
            ship_req_q     <= 1'b0;
            wake_en_q      <= 1'b0;
        end else begin
            pass_enable_q <= 1'b0;
            if (ship_done) begin
                ship_req_q <= 1'b0;
            end
            if (wake_en_q && !battery_low) begin
                wake_en_q <= 1'b0;
            end
            if (wake_done) begin
                wake_en_q <= 1'b0;
            end
            if (charge_current_write) begin
                wake_en_q <= 1'b0;
            end
            if (ctrl_wr) begin
                ref_sel_q      <= reg_wdata[`BIT_REF_SEL];
                polarity_q     <= reg_wdata[`BIT_POLARITY];
                deg_sel_q      <= reg_wdata[`BIT_DEG_HI:`BIT_DEG_LO];
                trip_disable_q <= reg_wdata[`BIT_TRIP_DISABLE];
                pass_enable_q  <= reg_wdata[`BIT_PASS_THROUGH];
                // write 0 stops, write 1 starts a new window only if none is running
                ship_req_q     <= reg_wdata[`BIT_SHIP_DISCHARGE];
                wake_en_q      <= reg_wdata[`BIT_AUTO_WAKEUP];
            end
        end
    end

    // force-off latch and its two-step release
    always @(posedge clk) begin
        if (reset) begin
            converter_latched_off_q <= 1'b0;
            released_q              <= 1'b0;
        end else if (trip_disable_q && !comparator_output_q) begin
            converter_latched_off_q <= 1'b1;
            released_q              <= 1'b0;
        end else if (converter_latched_off_q) begin
            // comparator high first, then bit cleared
            if (released_q && !trip_disable_q) begin
                converter_latched_off_q <= 1'b0;
                released_q              <= 1'b0;
            end else if (comparator_output_q && trip_disable_q) begin
                released_q <= 1'b1;
            end
        end
    end

    // outputs that follow the latch and the timed actions
    always @(posedge clk) begin
        if (reset) begin
            charger_good_indication_q         <= 1'b1;
            charge_current_force_zero_q       <= 1'b0;
            pass_through_mode_q               <= 1'b0;
            battery_sense_negative_pin_sink_q <= 1'b0;
            auto_wakeup_charge_256ma_q        <= 1'b0;
        end else begin
            // charger good drops with the trip
            charger_good_indication_q <= !(converter_latched_off_q ||
                                           (trip_disable_q && !comparator_output_q));
            charge_current_force_zero_q <= converter_latched_off_q ||
                                           (trip_disable_q && !comparator_output_q);
            // mode held until reset; nothing else clears it
            if (pass_enable_q) begin
                pass_through_mode_q <= 1'b1;
            end
            battery_sense_negative_pin_sink_q <= ship_req_q && !ship_done;
            auto_wakeup_charge_256ma_q <= wake_active && !wake_done;
        end
    end

    // register read, one cycle later; unmapped reads return zero
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata_q <= `CTRL_RESET;
        end else if (reg_rd) begin
            if (reg_addr == `CTRL_ADDR) begin
                reg_rdata_q <= {ref_sel_q, polarity_q, deg_sel_q, trip_disable_q,
                                pass_enable_q, ship_req_q, wake_en_q};
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

endmodule // charge_option_control

// >>> afe_model.sv
`timescale 1ns/10ps

// analog front end stand-in: millivolt levels to comparator results
module afe_model (
    // levels
    input  wire [15:0] cmp_mv,
    input  wire [15:0] bat_mv,
    // results
    output wire        above_2v3,
    output wire        above_1v2,
    output wire        bat_low
);
    // fixed thresholds; no hysteresis, so tests keep levels well apart
    assign above_2v3 = cmp_mv > 16'h08FC;
    assign above_1v2 = cmp_mv > 16'h04B0;
    assign bat_low   = bat_mv < 16'h0BB8;
endmodule // afe_model

// >>> co_props_properties.sv
`timescale 1ns/10ps
`include "charge_option_defines.vh"

module co_props #(
    parameter [63:0] DEG1_CYC = 64'h14,
    parameter [63:0] DEG2_CYC = 64'h1E,
    parameter [63:0] DEG3_CYC = 64'h28,
    parameter [63:0] SHIP_CYC = 64'h64,
    parameter [63:0] WAKE_CYC = 64'hC8
) (
    // clock, reset and host writes
    input wire       clk,
    input wire       reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    // pins
    input wire       comparator_input_above_2v3,
    input wire       comparator_input_above_1v2,
    input wire       comparator_output_q,
    input wire       charger_good_indication_q,
    input wire       converter_latched_off_q,
    input wire       charge_current_force_zero_q,
    input wire       battery_sense_negative_pin_sink_q,
    input wire       auto_wakeup_charge_256ma_q
);
    reg  [7:0]  fld_q;
    reg  [63:0] low_q;
    reg  [63:0] ship_q;
    reg  [63:0] wake_q;
    wire        raw_low = fld_q[6] ^ (fld_q[7] ? comparator_input_above_1v2
                                               : comparator_input_above_2v3);
    wire [63:0] lim = fld_q[5] ? (fld_q[4] ? DEG3_CYC : DEG2_CYC)
                               : (fld_q[4] ? DEG1_CYC : `DEG_CODE0_CYC);

    // shadow fields and run lengths; raw count leads the synchroniser
    always @(posedge clk) begin
        if (reset) begin
            fld_q  <= 8'h00;
            low_q  <= 64'h0;
            ship_q <= 64'h0;
            wake_q <= 64'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h30)
                fld_q <= reg_wdata;
            low_q  <= raw_low ? low_q + 64'h1 : 64'h0;
            ship_q <= battery_sense_negative_pin_sink_q ? ship_q + 64'h1 : 64'h0;
            wake_q <= auto_wakeup_charge_256ma_q ? wake_q + 64'h1 : 64'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_TRIP_FLAGS: assert property (converter_latched_off_q |->
        !charger_good_indication_q && charge_current_force_zero_q) else $error("latch flags");
    AST_LATCH_NEEDS_TRIP: assert property ($rose(converter_latched_off_q) |->
        !$past(comparator_output_q) && $past(fld_q[3])) else $error("latch without trip");
    AST_RELEASE_ORDER: assert property ($fell(converter_latched_off_q) |->
        comparator_output_q && !fld_q[3]) else $error("release out of order");
    AST_SHIP_START: assert property (reg_wr && reg_addr == 8'h30 && reg_wdata[1] |->
        ##3 battery_sense_negative_pin_sink_q) else $error("sink not started");
    AST_SHIP_WINDOW: assert property (ship_q <= SHIP_CYC)
        else $error("sink window too long");
    AST_WAKE_LIMIT: assert property (wake_q <= WAKE_CYC)
        else $error("wake charge too long");
    AST_FALL_DEGLITCH: assert property ($fell(comparator_output_q) |-> low_q >= lim)
        else $error("fall before deglitch");
    AST_RISE_PROMPT: assert property ((!raw_low) [*8] |-> comparator_output_q)
        else $error("rise delayed");
endmodule // co_props

bind charge_option_control co_props #(
    .DEG1_CYC(DEG1_CYC),
    .DEG2_CYC(DEG2_CYC),
    .DEG3_CYC(DEG3_CYC),
    .SHIP_CYC(SHIP_CYC),
    .WAKE_CYC(WAKE_CYC)
) u_props (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .comparator_input_above_2v3,
    .comparator_input_above_1v2, .comparator_output_q, .charger_good_indication_q,
    .converter_latched_off_q, .charge_current_force_zero_q,
    .battery_sense_negative_pin_sink_q, .auto_wakeup_charge_256ma_q);

// >>> charge_option_low_byte_control_tb.sv
`timescale 1ns/10ps
`include "charge_option_defines.vh"

module charge_option_low_byte_control_tb;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [7:0]  addr = 8'h00;
    reg  [7:0]  wdata = 8'h00;
    reg         wr_p = 1'b0;
    reg         rd_p = 1'b0;
    reg         cc_wr = 1'b0;
    reg  [15:0] cmp_mv = 16'h0000;
    reg  [15:0] bat_mv = 16'h0FA0;
    wire [7:0]  rdata;
    wire        a23, a12, blow, cmp, good, lat, zero, pass_through_mode, sink, wake;
    integer     mismatches = 0;
    integer     cmp_count = 0;
    integer     cycles = 0;
    integer     seed = 32'hA881;
    integer     c;
    reg  [7:0]  d;

    always #50 clk = ~clk;

    afe_model u_afe (.cmp_mv(cmp_mv), .bat_mv(bat_mv), .above_2v3(a23), .above_1v2(a12),
        .bat_low(blow));
    // short counts keep the run brief
    charge_option_control #(.DEG1_CYC(64'h14), .DEG2_CYC(64'h1E), .DEG3_CYC(64'h28),
        .SHIP_CYC(64'h64), .WAKE_CYC(64'hC8)) u_dut (.clk(clk), .reset(reset),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_p), .reg_rd(rd_p), .reg_rdata_q(rdata),
        .charge_current_write(cc_wr), .comparator_input_above_2v3(a23),
        .comparator_input_above_1v2(a12), .battery_below_minimum_system_voltage(blow),
        .comparator_output_q(cmp), .charger_good_indication_q(good),
        .converter_latched_off_q(lat), .charge_current_force_zero_q(zero),
        .pass_through_mode_q(pass_through_mode), .battery_sense_negative_pin_sink_q(sink),
        .auto_wakeup_charge_256ma_q(wake));

    task summarize;
        begin
            $display("compares %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] seen, input [63:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // one pulse, then a spare cycle so pulses never merge
    task wr(input [7:0] a, input [7:0] v);
        begin
            addr = a;
            wdata = v;
            wr_p = 1'b1;
            cyc(1);
            wr_p = 1'b0;
            cyc(1);
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp, input string what);
        begin
            addr = a;
            rd_p = 1'b1;
            cyc(1);
            rd_p = 1'b0;
            chk(rdata, exp, what);
            cyc(1);
        end
    endtask
    function integer deg_lim(input [1:0] code);
        deg_lim = code == 2'h0 ? 50 : 10 + 10 * code;
    endfunction

    // hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end

    initial begin
        cyc(10);
        reset = 1'b0;
        cyc(1);
        rd(`CTRL_ADDR, `CTRL_RESET, "reset byte");
        chk({cmp, good, lat, zero, pass_through_mode, sink, wake}, 64'h60, "reset pins");
        wr(8'h31, 8'hFF);
        rd(8'h31, 8'h00, "other address");
        // random fields over one random level; a level change here would race the sync
        cmp_mv = 16'($random(seed)) & 16'h0FFF;
        for (c = 0; c < 8; c = c + 1) begin
            d = 8'($random(seed)) & 8'hF0;
            wr(8'h30, d);
            rd(8'h30, d, "field readback");
        end
        cmp_mv = 16'h0708;
        for (c = 0; c < 4; c = c + 1) begin
            wr(8'h30, {c[1:0], 6'h00});
            cyc(70);
            chk(cmp, {63'h0, ~(c[1] ^ c[0])}, "ref and polarity");
        end
        for (c = 0; c < 4; c = c + 1) begin
            cmp_mv = 16'h0000;
            wr(8'h30, {2'h0, c[1:0], 4'h0});
            cyc(8);
            cmp_mv = 16'h09C4;
            // four sync edges, then limit plus one edges of low request
            cyc(deg_lim(c[1:0]) + 4);
            chk(cmp, 64'h1, "held by deglitch");
            cyc(1);
            chk(cmp, 64'h0, "falls after deglitch");
            cmp_mv = 16'h0000;
            cyc(5);
            chk(cmp, 64'h1, "rises at once");
        end
        wr(8'h30, 8'h08);
        cmp_mv = 16'h09C4;
        cyc(70);
        chk({lat, good, zero}, 64'h5, "trip latch");
        wr(8'h30, 8'h00);
        cmp_mv = 16'h0000;
        cyc(10);
        chk(lat, 64'h1, "early clear");
        wr(8'h30, 8'h08);
        wr(8'h30, 8'h00);
        cyc(2);
        chk({lat, good, zero}, 64'h2, "released");
        wr(8'h30, 8'h02);
        cyc(1);
        chk(sink, 64'h1, "sink on");
        rd(8'h30, 8'h02, "ship bit live");
        cyc(100);
        rd(8'h30, 8'h00, "ship bit cleared");
        wr(8'h30, 8'h02);
        cyc(10);
        chk(sink, 64'h1, "second window");
        wr(8'h30, 8'h00);
        cyc(1);
        chk(sink, 64'h0, "host stop");
        wr(8'h30, 8'h04);
        chk(pass_through_mode, 64'h1, "pass-through on");
        rd(8'h30, 8'h00, "pass-through bit");
        bat_mv = 16'h07D0;
        for (c = 0; c < 3; c = c + 1) begin
            // low battery must be through the sync before enabling, or it clears at once
            cyc(4);
            wr(8'h30, 8'h01);
            cyc(8);
            chk(wake, 64'h1, "wake charge");
            if (c == 0)
                bat_mv = 16'h0FA0;
            else if (c == 1)
                cc_wr = 1'b1;
            cyc(c == 2 ? 210 : 1);
            cc_wr = 1'b0;
            cyc(8);
            bat_mv = 16'h07D0;
            chk(wake, 64'h0, "wake ended");
            rd(8'h30, 8'h00, "wake bit cleared");
        end
        summarize;
    end
endmodule // charge_option_low_byte_control_tb
